// >>> design/mfemd_defines.vh
// Constants for the meter front-end mode decoder: register map, fields, resets, codes.
// Assumes a 32-bit plain register port with byte addresses on aligned words.
`ifndef MFEMD_DEFINES_VH
`define MFEMD_DEFINES_VH

`define MFEMD_OFS_MODE      8'h00
`define MFEMD_OFS_SUPPLY    8'h04
`define MFEMD_OFS_SUBCTL    8'h08
`define MFEMD_OFS_PROT      8'h0c
`define MFEMD_OFS_STATUS    8'h10

`define MFEMD_SUP_REG2V_BIT   8
`define MFEMD_SUP_CHARGE_BIT  0
`define MFEMD_SUB_HIRES_LSB   5
`define MFEMD_SUB_HIRES_MSB   8
`define MFEMD_SUB_BIAS_LSB    2
`define MFEMD_SUB_BIAS_MSB    4
`define MFEMD_MODE_FUNC_MSB   3
`define MFEMD_MODE_RANGE_LSB  4
`define MFEMD_MODE_RANGE_MSB  6

`define MFEMD_RST_REG2V     1'b1
`define MFEMD_RST_CHARGE    1'b0
`define MFEMD_RST_HIRES     4'h0
`define MFEMD_RST_BIAS      3'h0
`define MFEMD_HIRES_ON      4'h8
`define MFEMD_PROT_KEY      16'h0096

`define MFEMD_FN_DCV        4'h0
`define MFEMD_FN_ACV        4'h1
`define MFEMD_FN_OHM_CV     4'h2
`define MFEMD_FN_OHM_CC     4'h3
`define MFEMD_FN_CONT_CV    4'h4
`define MFEMD_FN_CONT_CC    4'h5

`define MFEMD_FLT_100K      2'h0
`define MFEMD_FLT_10K       2'h1
`define MFEMD_FLT_0R        2'h2
`define MFEMD_FLT_BYPASS    2'h3

`endif

// >>> design/mfemd_mode_rom.v
// Registered decode table: function and range code to analog network settings.
// Assumes the caller strobes rd_en_in once per mode change; outputs hold otherwise.
`timescale 1ns/1ns
`include "mfemd_defines.vh"

module mfemd_mode_rom (
	input  wire       clk_in,
	input  wire       nrst_in,
	input  wire       rd_en_in,
	input  wire [3:0] func_in,
	input  wire [2:0] range_in,
	output reg        hit_out,
	output reg  [6:0] discharge_out,
	output reg  [6:0] positive_out,
	output reg  [6:0] series_out,
	output reg  [6:0] feedback_out,
	output reg  [2:0] cmp_in_out,
	output reg  [3:0] mamp_ref_out,
	output reg  [6:0] smode_out,
	output reg  [2:0] flt_neg_out,
	output reg  [3:0] flt_pos_out,
	output reg  [3:0] cmp_lo_out,
	output reg  [3:0] cmp_hi_out,
	output reg  [2:0] conv_lo_out,
	output reg  [2:0] conv_hi_out,
	output reg  [2:0] gnd_ref_out,
	output reg  [1:0] flt_mode_out,
	output reg        cmp_en_out,
	output reg        main_amp_out,
	output reg        ext_ref_out,
	output reg        on_out
);
	reg       ok;
	reg [6:0] ds, ps, ss, sm;
	reg [2:0] ci, cl, ch, gr, fn;
	reg [3:0] mr, fp, tl, th;
	reg [1:0] fm;
	reg       ce, ma, er;
	reg [3:0] ohm_fn;

	always @* begin
		ok = 1'b0; ds = 7'h00; ps = 7'h00; ss = 7'h00; sm = 7'h20;
		ci = 3'h0; cl = 3'h7; ch = 3'h7; gr = 3'h0; fn = 3'h5;
		mr = 4'h0; fp = 4'h8; tl = 4'h0; th = 4'h0; fm = `MFEMD_FLT_100K;
		ce = 1'b0; ma = 1'b0; er = 1'b0;
		ohm_fn = func_in;
		if (func_in == `MFEMD_FN_CONT_CV)
			ohm_fn = `MFEMD_FN_OHM_CV;
		if (func_in == `MFEMD_FN_CONT_CC)
			ohm_fn = `MFEMD_FN_OHM_CC;
		case (func_in)
			`MFEMD_FN_DCV, `MFEMD_FN_ACV: begin
				ok = (range_in <= 3'h4);
				fm = (func_in == `MFEMD_FN_ACV) ? `MFEMD_FLT_BYPASS : `MFEMD_FLT_100K;
				fn = (range_in == 3'h0) ? 3'h5 : 3'h1;
				fp = (range_in == 3'h0) ? 4'h2 : 4'h0;
				case (range_in)
					3'h0: begin ps = 7'h40; ss = 7'h00; sm = 7'h11; end
					3'h1: begin ps = 7'h60; ss = 7'h20; end
					3'h2: begin ps = 7'h48; ss = 7'h08; end
					3'h3: begin ps = 7'h42; ss = 7'h02; end
					default: begin ps = 7'h41; ss = 7'h01; end
				endcase
			end
			default: begin
				ok = (func_in == `MFEMD_FN_OHM_CV && range_in <= 3'h2) ||
				     (func_in == `MFEMD_FN_OHM_CC && range_in <= 3'h5) ||
				     func_in == `MFEMD_FN_CONT_CV || func_in == `MFEMD_FN_CONT_CC;
				ma = 1'b1;
				if (ohm_fn == `MFEMD_FN_OHM_CV) begin
					ds = (func_in == `MFEMD_FN_CONT_CV) ? 7'h01 :
					     (range_in == 3'h0) ? 7'h01 : (range_in == 3'h1) ? 7'h02 : 7'h08;
					sm = 7'h14; mr = 4'h7; cl = 3'h0; ch = 3'h0; gr = 3'h1; er = 1'b1;
				end else begin
					sm = 7'h06; gr = 3'h4;
					mr = (range_in == 3'h0 || func_in == `MFEMD_FN_CONT_CC) ? 4'h8 : 4'h1;
					case (func_in == `MFEMD_FN_CONT_CC ? 3'h0 : range_in)
						3'h0, 3'h1: ps = 7'h01;
						3'h2: ps = 7'h02;
						3'h3: ps = 7'h18;
						3'h4: ps = 7'h30;
						default: ps = 7'h10;
					endcase
				end
				if (func_in == `MFEMD_FN_CONT_CV || func_in == `MFEMD_FN_CONT_CC) begin
					ce = 1'b1; ci = 3'h3; tl = 4'hd; th = 4'hd;
					// Continuity CC keeps the CV switch mode
					sm = 7'h14;
				end
			end
		endcase
	end

	// Invalid codes leave the network as it was
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			hit_out <= 1'b0; discharge_out <= 7'h00; positive_out <= 7'h00;
			series_out <= 7'h00; feedback_out <= 7'h00; cmp_in_out <= 3'h0;
			mamp_ref_out <= 4'h0; smode_out <= 7'h00; flt_neg_out <= 3'h0;
			flt_pos_out <= 4'h0; cmp_lo_out <= 4'h0; cmp_hi_out <= 4'h0;
			conv_lo_out <= 3'h0; conv_hi_out <= 3'h0; gnd_ref_out <= 3'h0;
			flt_mode_out <= 2'h0; cmp_en_out <= 1'b0; main_amp_out <= 1'b0;
			ext_ref_out <= 1'b0; on_out <= 1'b0;
		end else if (rd_en_in) begin
			hit_out <= ok;
			if (ok) begin
				discharge_out <= ds; positive_out <= ps; series_out <= ss;
				feedback_out <= ds; cmp_in_out <= ci; mamp_ref_out <= mr;
				smode_out <= sm; flt_neg_out <= fn; flt_pos_out <= fp;
				cmp_lo_out <= tl; cmp_hi_out <= th; conv_lo_out <= cl;
				conv_hi_out <= ch; gnd_ref_out <= gr; flt_mode_out <= fm;
				cmp_en_out <= ce; main_amp_out <= ma; ext_ref_out <= er;
				on_out <= 1'b1;
			end
		end
	end
endmodule // mfemd_mode_rom

// >>> design/mfemd_top.v
// Meter front-end mode decoder: register port, supply and sub-control bits, network drive.
// Assumes a synchronous register master with one-cycle strobes and a read answer one
// cycle later; the analog network consumes the levels and never answers back.
`timescale 1ns/1ns
`include "mfemd_defines.vh"

module mfemd_top (
	input  wire        CLOCK_IN,
	input  wire        NRST_IN,
	input  wire [7:0]  ADDR_IN,
	input  wire [31:0] WDATA_IN,
	input  wire        WR_IN,
	input  wire        RD_IN,
	output reg  [31:0] RDATA_OUT,
	output wire        NETWORK_RESET_RELEASE_OUT,
	output wire        NETWORK_ENABLE_OUT,
	output wire        REGULATOR_2V_ENABLE_OUT,
	output wire        CHARGE_REGULATOR_ENABLE_OUT,
	output wire        GROUND_AMP_ENABLE_OUT,
	output wire        MODULATOR_ENABLE_OUT,
	output wire        REF_PAIR_ENABLE_OUT,
	output wire        COMMON_MODE_OUT_ENABLE_OUT,
	output wire        TEMP_SENSOR_ENABLE_OUT,
	output wire        EXTERNAL_REF_SELECT_OUT,
	output wire        WINDOW_COMPARATOR_ENABLE_OUT,
	output wire        MAIN_AMP_ENABLE_OUT,
	output wire        DIODE_SWITCH_SELECT_OUT,
	output wire [1:0]  FILTER_MODE_CODE_OUT,
	output wire [6:0]  SWITCH_MODE_CODE_OUT,
	output wire [6:0]  POSITIVE_SWITCH_CODE_OUT,
	output wire [6:0]  SERIES_SWITCH_CODE_OUT,
	output wire [6:0]  DISCHARGE_SWITCH_CODE_OUT,
	output wire [6:0]  FEEDBACK_SWITCH_CODE_OUT,
	output wire [2:0]  COMPARATOR_INPUT_CODE_OUT,
	output wire [3:0]  MAIN_AMP_REFERENCE_CODE_OUT,
	output wire [3:0]  COMPARATOR_LOW_THRESHOLD_OUT,
	output wire [3:0]  COMPARATOR_HIGH_THRESHOLD_OUT,
	output wire [2:0]  CONVERTER_LOW_REF_SELECT_OUT,
	output wire [2:0]  CONVERTER_HIGH_REF_SELECT_OUT,
	output wire [2:0]  GROUND_REFERENCE_CODE_OUT,
	output wire [2:0]  FILTER_NEG_INPUT_SELECT_OUT,
	output wire [3:0]  FILTER_POS_INPUT_SELECT_OUT,
	output wire        HIGH_RES_MODE_OUT,
	output wire [3:0]  HIGH_RES_MODE_CODE_OUT,
	output wire [2:0]  CHOPPER_BUFFER_BIAS_CODE_OUT
);
	reg  [3:0]  measure_function_code_r;
	reg  [2:0]  measure_range_code_r;
	reg         regulator_2v_enable_r;
	reg         charge_regulator_enable_r;
	reg  [3:0]  high_res_mode_code_r;
	reg  [2:0]  chopper_buffer_bias_code_r;
	reg         unlocked_r;
	reg         load_req_r;
	reg         load_apply_r;
	reg  [31:0] rdata_nxt;

	wire        wr_mode;
	wire        wr_supply;
	wire        wr_subctl;
	wire        wr_prot;
	wire        rom_hit;
	wire        rom_on;
	wire [6:0]  rom_discharge;
	wire [6:0]  rom_positive;
	wire [6:0]  rom_series;
	wire [6:0]  rom_feedback;
	wire [2:0]  rom_cmp_in;
	wire [3:0]  rom_mamp_ref;
	wire [6:0]  rom_smode;
	wire [2:0]  rom_flt_neg;
	wire [3:0]  rom_flt_pos;
	wire [3:0]  rom_cmp_lo;
	wire [3:0]  rom_cmp_hi;
	wire [2:0]  rom_conv_lo;
	wire [2:0]  rom_conv_hi;
	wire [2:0]  rom_gnd_ref;
	wire [1:0]  rom_flt_mode;
	wire        rom_cmp_en;
	wire        rom_main_amp;
	wire        rom_ext_ref;

	assign wr_mode   = WR_IN && (ADDR_IN == `MFEMD_OFS_MODE);
	assign wr_supply = WR_IN && (ADDR_IN == `MFEMD_OFS_SUPPLY);
	assign wr_subctl = WR_IN && (ADDR_IN == `MFEMD_OFS_SUBCTL);
	assign wr_prot   = WR_IN && (ADDR_IN == `MFEMD_OFS_PROT);

	// Mode selection; a write starts a table load on the next edge
	always @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			measure_function_code_r <= 4'h0;
			measure_range_code_r    <= 3'h0;
			load_req_r              <= 1'b0;
		end else begin
			load_req_r <= wr_mode;
			if (wr_mode) begin
				measure_function_code_r <= WDATA_IN[`MFEMD_MODE_FUNC_MSB:0];
				measure_range_code_r    <=
					WDATA_IN[`MFEMD_MODE_RANGE_MSB:`MFEMD_MODE_RANGE_LSB];
			end
		end
	end

	mfemd_mode_rom u_rom (
		.clk_in        (CLOCK_IN),
		.nrst_in       (NRST_IN),
		.rd_en_in      (load_req_r),
		.func_in       (measure_function_code_r),
		.range_in      (measure_range_code_r),
		.hit_out       (rom_hit),
		.discharge_out (rom_discharge),
		.positive_out  (rom_positive),
		.series_out    (rom_series),
		.feedback_out  (rom_feedback),
		.cmp_in_out    (rom_cmp_in),
		.mamp_ref_out  (rom_mamp_ref),
		.smode_out     (rom_smode),
		.flt_neg_out   (rom_flt_neg),
		.flt_pos_out   (rom_flt_pos),
		.cmp_lo_out    (rom_cmp_lo),
		.cmp_hi_out    (rom_cmp_hi),
		.conv_lo_out   (rom_conv_lo),
		.conv_hi_out   (rom_conv_hi),
		.gnd_ref_out   (rom_gnd_ref),
		.flt_mode_out  (rom_flt_mode),
		.cmp_en_out    (rom_cmp_en),
		.main_amp_out  (rom_main_amp),
		.ext_ref_out   (rom_ext_ref),
		.on_out        (rom_on)
	);

	// Supply bits: software writes, and a valid mode load forces both on.
	// A software write in the apply cycle wins, being the newer intent.
	always @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			load_apply_r              <= 1'b0;
			regulator_2v_enable_r     <= `MFEMD_RST_REG2V;
			charge_regulator_enable_r <= `MFEMD_RST_CHARGE;
		end else begin
			load_apply_r <= load_req_r;
			if (wr_supply) begin
				regulator_2v_enable_r     <= WDATA_IN[`MFEMD_SUP_REG2V_BIT];
				charge_regulator_enable_r <= WDATA_IN[`MFEMD_SUP_CHARGE_BIT];
			end else if (load_apply_r && rom_hit) begin
				regulator_2v_enable_r     <= 1'b1;
				charge_regulator_enable_r <= 1'b1;
			end
		end
	end

	// Write protection: the key opens, any other value closes
	always @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			unlocked_r <= 1'b0;
		end else if (wr_prot) begin
			unlocked_r <= (WDATA_IN[15:0] == `MFEMD_PROT_KEY);
		end
	end

	// Sub-control fields accept writes only while unlocked; reserved bits are dropped
	always @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			high_res_mode_code_r       <= `MFEMD_RST_HIRES;
			chopper_buffer_bias_code_r <= `MFEMD_RST_BIAS;
		end else if (wr_subctl && unlocked_r) begin
			high_res_mode_code_r       <=
				WDATA_IN[`MFEMD_SUB_HIRES_MSB:`MFEMD_SUB_HIRES_LSB];
			chopper_buffer_bias_code_r <=
				WDATA_IN[`MFEMD_SUB_BIAS_MSB:`MFEMD_SUB_BIAS_LSB];
		end
	end

	// Read mux; unmapped addresses answer zero
	always @* begin
		rdata_nxt = 32'h0000_0000;
		case (ADDR_IN)
			`MFEMD_OFS_MODE: begin
				rdata_nxt[`MFEMD_MODE_FUNC_MSB:0] = measure_function_code_r;
				rdata_nxt[`MFEMD_MODE_RANGE_MSB:`MFEMD_MODE_RANGE_LSB] =
					measure_range_code_r;
			end
			`MFEMD_OFS_SUPPLY: begin
				rdata_nxt[`MFEMD_SUP_REG2V_BIT]  = regulator_2v_enable_r;
				rdata_nxt[`MFEMD_SUP_CHARGE_BIT] = charge_regulator_enable_r;
			end
			`MFEMD_OFS_SUBCTL: begin
				rdata_nxt[`MFEMD_SUB_HIRES_MSB:`MFEMD_SUB_HIRES_LSB] = high_res_mode_code_r;
				rdata_nxt[`MFEMD_SUB_BIAS_MSB:`MFEMD_SUB_BIAS_LSB] =
					chopper_buffer_bias_code_r;
			end
			`MFEMD_OFS_PROT: begin
				rdata_nxt[0] = unlocked_r;
			end
			`MFEMD_OFS_STATUS: begin
				rdata_nxt[0] = load_req_r | load_apply_r;
				rdata_nxt[1] = rom_hit;
				rdata_nxt[2] = HIGH_RES_MODE_OUT;
				rdata_nxt[3] = rom_on;
			end
			default: begin
				rdata_nxt = 32'h0000_0000;
			end
		endcase
	end

	// Answer stands only in the cycle after the read strobe
	always @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			RDATA_OUT <= 32'h0000_0000;
		end else if (RD_IN) begin
			RDATA_OUT <= rdata_nxt;
		end else begin
			RDATA_OUT <= 32'h0000_0000;
		end
	end

	// Common enables follow a loaded mode; zero until the first valid load
	assign NETWORK_RESET_RELEASE_OUT    = rom_on;
	assign NETWORK_ENABLE_OUT           = rom_on;
	assign GROUND_AMP_ENABLE_OUT        = rom_on;
	assign MODULATOR_ENABLE_OUT         = rom_on;
	assign REF_PAIR_ENABLE_OUT          = rom_on;
	assign COMMON_MODE_OUT_ENABLE_OUT   = rom_on;
	// Voltage and resistance modes never use the sensor
	assign TEMP_SENSOR_ENABLE_OUT       = 1'b0;
	assign DIODE_SWITCH_SELECT_OUT      = 1'b0;
	assign REGULATOR_2V_ENABLE_OUT      = regulator_2v_enable_r;
	assign CHARGE_REGULATOR_ENABLE_OUT  = charge_regulator_enable_r;
	assign EXTERNAL_REF_SELECT_OUT      = rom_ext_ref;
	assign WINDOW_COMPARATOR_ENABLE_OUT = rom_cmp_en;
	assign MAIN_AMP_ENABLE_OUT          = rom_main_amp;
	assign FILTER_MODE_CODE_OUT         = rom_flt_mode;
	assign SWITCH_MODE_CODE_OUT         = rom_smode;
	assign POSITIVE_SWITCH_CODE_OUT     = rom_positive;
	assign SERIES_SWITCH_CODE_OUT       = rom_series;
	assign DISCHARGE_SWITCH_CODE_OUT    = rom_discharge;
	assign FEEDBACK_SWITCH_CODE_OUT     = rom_feedback;
	assign COMPARATOR_INPUT_CODE_OUT    = rom_cmp_in;
	assign MAIN_AMP_REFERENCE_CODE_OUT  = rom_mamp_ref;
	assign COMPARATOR_LOW_THRESHOLD_OUT = rom_cmp_lo;
	assign COMPARATOR_HIGH_THRESHOLD_OUT = rom_cmp_hi;
	assign CONVERTER_LOW_REF_SELECT_OUT = rom_conv_lo;
	assign CONVERTER_HIGH_REF_SELECT_OUT = rom_conv_hi;
	assign GROUND_REFERENCE_CODE_OUT    = rom_gnd_ref;
	assign FILTER_NEG_INPUT_SELECT_OUT  = rom_flt_neg;
	assign FILTER_POS_INPUT_SELECT_OUT  = rom_flt_pos;
	// Other codes are reserved and leave the network in normal mode
	assign HIGH_RES_MODE_OUT            = (high_res_mode_code_r == `MFEMD_HIRES_ON);
	assign HIGH_RES_MODE_CODE_OUT       = high_res_mode_code_r;
	// Bias decode (0.25x..1x) lives in the analog cell; codes pass unchanged
	assign CHOPPER_BUFFER_BIAS_CODE_OUT = chopper_buffer_bias_code_r;
endmodule // mfemd_top

// >>> bench/mfemd_net_model.sv
// Behavioural analog network on the far side of the mode decoder.
// Assumes it only watches decoded levels; it never drives anything back.
`timescale 1ns/1ns
module mfemd_net_model (
	input  wire logic       net_en_in,
	input  wire logic       reg2v_in,
	input  wire logic       charge_in,
	input  wire logic       mod_en_in,
	input  wire logic [1:0] flt_mode_in,
	input  wire logic [2:0] bias_in,
	output logic            powered_out,
	output int              flt_ohm_out,
	output int              bias_milli_out
);
	// Network is usable only with both supplies and the modulator up
	assign powered_out = net_en_in && reg2v_in && charge_in && mod_en_in;
	always_comb begin
		case (flt_mode_in)
			2'h0: flt_ohm_out = 100000;
			2'h1: flt_ohm_out = 10000;
			2'h2: flt_ohm_out = 0;
			default: flt_ohm_out = -1;
		endcase
		case (bias_in)
			3'h0: bias_milli_out = 625;
			3'h1: bias_milli_out = 500;
			3'h2: bias_milli_out = 375;
			3'h3: bias_milli_out = 250;
			default: bias_milli_out = 1000;
		endcase
	end
endmodule // mfemd_net_model

// >>> bench/mfemd_checker.sv
// Concurrent checks on the mode decoder top: supply bits and decoded network levels.
// Assumes it is bound onto mfemd_top; each input mirrors a top-level port by name.
`timescale 1ns/1ns
module mfemd_checker (
	input wire logic        CLOCK_IN,
	input wire logic        NRST_IN,
	input wire logic [7:0]  ADDR_IN,
	input wire logic [31:0] WDATA_IN,
	input wire logic        WR_IN,
	input wire logic        REGULATOR_2V_ENABLE_OUT,
	input wire logic        CHARGE_REGULATOR_ENABLE_OUT,
	input wire logic        TEMP_SENSOR_ENABLE_OUT,
	input wire logic        EXTERNAL_REF_SELECT_OUT,
	input wire logic        WINDOW_COMPARATOR_ENABLE_OUT,
	input wire logic [1:0]  FILTER_MODE_CODE_OUT,
	input wire logic [6:0]  SWITCH_MODE_CODE_OUT,
	input wire logic [6:0]  POSITIVE_SWITCH_CODE_OUT,
	input wire logic [2:0]  COMPARATOR_INPUT_CODE_OUT,
	input wire logic [3:0]  MAIN_AMP_REFERENCE_CODE_OUT,
	input wire logic [3:0]  COMPARATOR_LOW_THRESHOLD_OUT,
	input wire logic [3:0]  COMPARATOR_HIGH_THRESHOLD_OUT,
	input wire logic [2:0]  CONVERTER_LOW_REF_SELECT_OUT,
	input wire logic [2:0]  CONVERTER_HIGH_REF_SELECT_OUT,
	input wire logic [2:0]  GROUND_REFERENCE_CODE_OUT,
	input wire logic        HIGH_RES_MODE_OUT,
	input wire logic [3:0]  HIGH_RES_MODE_CODE_OUT
);
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!NRST_IN);
	sequence s_sup_wr;
		WR_IN && ADDR_IN == 8'h04;
	endsequence
	// Voltage functions only; the load lands two edges after the write
	sequence s_volt_ld;
		WR_IN && ADDR_IN == 8'h00 && WDATA_IN[3:1] == 3'h0 && WDATA_IN[6:4] <= 3'h4;
	endsequence
	a_reg2v_write: assert property (
		s_sup_wr |=> REGULATOR_2V_ENABLE_OUT == $past(WDATA_IN[8]))
		else $error("2V regulator enable differs from written bit");
	a_charge_write: assert property (
		s_sup_wr |=> CHARGE_REGULATOR_ENABLE_OUT == $past(WDATA_IN[0]))
		else $error("charge regulator enable differs from written bit");
	a_hires_decode: assert property (
		HIGH_RES_MODE_OUT == (HIGH_RES_MODE_CODE_OUT == 4'h8))
		else $error("high resistance flag does not match its code");
	a_temp_off: assert property (!TEMP_SENSOR_ENABLE_OUT)
		else $error("temperature sensor enabled");
	// A supply write taken in the force cycle wins, so that case is left out
	a_supply_forced: assert property (
		s_volt_ld ##2 !(WR_IN && ADDR_IN == 8'h04) |-> ##1
		(REGULATOR_2V_ENABLE_OUT && CHARGE_REGULATOR_ENABLE_OUT))
		else $error("supplies not forced on after mode load");
	a_volt_refs: assert property (
		s_volt_ld |-> ##2 (CONVERTER_LOW_REF_SELECT_OUT == 3'h7
		&& CONVERTER_HIGH_REF_SELECT_OUT == 3'h7 && GROUND_REFERENCE_CODE_OUT == 3'h0
		&& COMPARATOR_INPUT_CODE_OUT == 3'h0 && !WINDOW_COMPARATOR_ENABLE_OUT
		&& FILTER_MODE_CODE_OUT == ($past(WDATA_IN[0], 2) ? 2'h3 : 2'h0)))
		else $error("voltage mode references or filter wrong");
	a_low_range: assert property (
		POSITIVE_SWITCH_CODE_OUT == 7'h40 |-> SWITCH_MODE_CODE_OUT == 7'h11)
		else $error("lowest voltage range switch mode wrong");
	a_cv_ohm: assert property (
		EXTERNAL_REF_SELECT_OUT |-> SWITCH_MODE_CODE_OUT == 7'h14
		&& MAIN_AMP_REFERENCE_CODE_OUT == 4'h7 && CONVERTER_LOW_REF_SELECT_OUT == 3'h0
		&& CONVERTER_HIGH_REF_SELECT_OUT == 3'h0 && GROUND_REFERENCE_CODE_OUT == 3'h1)
		else $error("constant voltage resistance settings wrong");
	a_cont_window: assert property (
		WINDOW_COMPARATOR_ENABLE_OUT |-> COMPARATOR_INPUT_CODE_OUT == 3'h3
		&& COMPARATOR_LOW_THRESHOLD_OUT == 4'hd && COMPARATOR_HIGH_THRESHOLD_OUT == 4'hd)
		else $error("continuity comparator settings wrong");
endmodule // mfemd_checker

bind mfemd_top mfemd_checker chk_u (.*);

// >>> bench/meter_front_end_mode_decoder_tb_top.sv
// Self-checking bench for the mode decoder: register tasks, mode loads, table compares.
// Assumes the decoder top and the network model; the checker arrives by bind.
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
	$display("ERROR %0t: mismatch at line %0d", $time, `__LINE__); end end
module meter_front_end_mode_decoder_tb_top;
	logic CLOCK_IN = 1'b0, NRST_IN = 1'b0, WR_IN = 1'b0, RD_IN = 1'b0;
	logic [7:0] ADDR_IN = 8'h00;
	logic [31:0] WDATA_IN = 32'h0;
	wire [31:0] RDATA_OUT;
	wire NETWORK_RESET_RELEASE_OUT, NETWORK_ENABLE_OUT, REGULATOR_2V_ENABLE_OUT;
	wire CHARGE_REGULATOR_ENABLE_OUT, GROUND_AMP_ENABLE_OUT, MODULATOR_ENABLE_OUT;
	wire REF_PAIR_ENABLE_OUT, COMMON_MODE_OUT_ENABLE_OUT, TEMP_SENSOR_ENABLE_OUT;
	wire EXTERNAL_REF_SELECT_OUT, WINDOW_COMPARATOR_ENABLE_OUT, MAIN_AMP_ENABLE_OUT;
	wire DIODE_SWITCH_SELECT_OUT, HIGH_RES_MODE_OUT;
	wire [1:0] FILTER_MODE_CODE_OUT;
	wire [6:0] SWITCH_MODE_CODE_OUT, POSITIVE_SWITCH_CODE_OUT, SERIES_SWITCH_CODE_OUT;
	wire [6:0] DISCHARGE_SWITCH_CODE_OUT, FEEDBACK_SWITCH_CODE_OUT;
	wire [2:0] COMPARATOR_INPUT_CODE_OUT, CONVERTER_LOW_REF_SELECT_OUT;
	wire [2:0] CONVERTER_HIGH_REF_SELECT_OUT, GROUND_REFERENCE_CODE_OUT;
	wire [2:0] FILTER_NEG_INPUT_SELECT_OUT, CHOPPER_BUFFER_BIAS_CODE_OUT;
	wire [3:0] MAIN_AMP_REFERENCE_CODE_OUT, COMPARATOR_LOW_THRESHOLD_OUT;
	wire [3:0] COMPARATOR_HIGH_THRESHOLD_OUT, FILTER_POS_INPUT_SELECT_OUT, HIGH_RES_MODE_CODE_OUT;
	logic net_pwr;
	int net_flt, net_bias, errors = 0, checks_done = 0;
	logic [6:0] pos_t [5] = '{7'h40, 7'h60, 7'h48, 7'h42, 7'h41};
	logic [6:0] ser_t [5] = '{7'h00, 7'h20, 7'h08, 7'h02, 7'h01};
	logic [6:0] ds_t [3] = '{7'h01, 7'h02, 7'h08};
	logic [6:0] cc_ps_t [6] = '{7'h01, 7'h01, 7'h02, 7'h18, 7'h30, 7'h10};
	int bias_t [8] = '{625, 500, 375, 250, 1000, 1000, 1000, 1000};

	mfemd_top dut_u (.*);
	mfemd_net_model net_u (
		.net_en_in      (NETWORK_ENABLE_OUT),
		.reg2v_in       (REGULATOR_2V_ENABLE_OUT),
		.charge_in      (CHARGE_REGULATOR_ENABLE_OUT),
		.mod_en_in      (MODULATOR_ENABLE_OUT),
		.flt_mode_in    (FILTER_MODE_CODE_OUT),
		.bias_in        (CHOPPER_BUFFER_BIAS_CODE_OUT),
		.powered_out    (net_pwr),
		.flt_ohm_out    (net_flt),
		.bias_milli_out (net_bias)
	);

	always #4 CLOCK_IN = ~CLOCK_IN;

	task automatic report_and_stop();
		if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// Ends just after the edge that takes the write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLOCK_IN);
		ADDR_IN <= a;
		WDATA_IN <= d;
		WR_IN <= 1'b1;
		@(posedge CLOCK_IN);
		WR_IN <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge CLOCK_IN);
		ADDR_IN <= a;
		RD_IN <= 1'b1;
		@(posedge CLOCK_IN);
		RD_IN <= 1'b0;
		#1;
		`CHK(RDATA_OUT, e)
	endtask

	// Network levels settle two edges after the write, supplies one edge later
	task automatic ld(input logic [3:0] f, input logic [2:0] r);
		wr(8'h00, {25'h0, r, f});
		repeat (3) @(posedge CLOCK_IN);
		#1;
	endtask

	initial begin
		#100000;
		errors++;
		report_and_stop();
	end

	initial begin
		repeat (12) @(posedge CLOCK_IN);
		NRST_IN <= 1'b1;
		@(posedge CLOCK_IN);
		#1;
		`CHK({REGULATOR_2V_ENABLE_OUT, CHARGE_REGULATOR_ENABLE_OUT, NETWORK_ENABLE_OUT}, 3'b100)
		wr(8'h04, 32'h1);
		`CHK({REGULATOR_2V_ENABLE_OUT, CHARGE_REGULATOR_ENABLE_OUT, net_pwr}, 3'b010)
		rd(8'h04, 32'h1);
		wr(8'h04, 32'h100);
		`CHK({REGULATOR_2V_ENABLE_OUT, CHARGE_REGULATOR_ENABLE_OUT}, 2'b10)
		rd(8'h04, 32'h100);
		rd(8'h20, 32'h0);
		rd(8'h08, 32'h0);
		// Locked: the write must not reach the field
		wr(8'h08, 32'h100);
		rd(8'h08, 32'h0);
		wr(8'h0c, 32'h96);
		rd(8'h0c, 32'h1);
		for (int b = 0; b < 8; b++) begin
			wr(8'h08, {23'h0, 4'h8, b[2:0], 2'b00});
			rd(8'h08, {23'h0, 4'h8, b[2:0], 2'b00});
			`CHK({HIGH_RES_MODE_OUT, CHOPPER_BUFFER_BIAS_CODE_OUT}, {1'b1, b[2:0]})
			`CHK(net_bias, bias_t[b])
		end
		wr(8'h08, 32'h0e0);
		`CHK({HIGH_RES_MODE_OUT, HIGH_RES_MODE_CODE_OUT}, 5'h07)
		wr(8'h0c, 32'h0);
		wr(8'h08, 32'h0);
		rd(8'h08, 32'h0e0);
		for (int f = 0; f < 2; f++) begin
			for (int r = 0; r < 5; r++) begin
				ld(f[3:0], r[2:0]);
				`CHK(POSITIVE_SWITCH_CODE_OUT, pos_t[r])
				`CHK(SERIES_SWITCH_CODE_OUT, ser_t[r])
				`CHK(SWITCH_MODE_CODE_OUT, (r == 0) ? 7'h11 : 7'h20)
				`CHK(FILTER_MODE_CODE_OUT, (f == 1) ? 2'h3 : 2'h0)
				`CHK(net_flt, (f == 1) ? -1 : 100000)
				`CHK({DISCHARGE_SWITCH_CODE_OUT, FEEDBACK_SWITCH_CODE_OUT, COMPARATOR_INPUT_CODE_OUT,
					MAIN_AMP_REFERENCE_CODE_OUT, GROUND_REFERENCE_CODE_OUT}, 24'h0)
				`CHK({CONVERTER_LOW_REF_SELECT_OUT, CONVERTER_HIGH_REF_SELECT_OUT,
					WINDOW_COMPARATOR_ENABLE_OUT, MAIN_AMP_ENABLE_OUT}, 8'hfc)
				`CHK({NETWORK_RESET_RELEASE_OUT, NETWORK_ENABLE_OUT, REGULATOR_2V_ENABLE_OUT,
					CHARGE_REGULATOR_ENABLE_OUT, GROUND_AMP_ENABLE_OUT, MODULATOR_ENABLE_OUT,
					REF_PAIR_ENABLE_OUT, COMMON_MODE_OUT_ENABLE_OUT, TEMP_SENSOR_ENABLE_OUT},
					9'h1fe)
				`CHK(net_pwr, 1'b1)
				`CHK({FILTER_NEG_INPUT_SELECT_OUT, FILTER_POS_INPUT_SELECT_OUT},
					(r == 0) ? 7'h52 : 7'h10)
				`CHK({COMPARATOR_LOW_THRESHOLD_OUT, COMPARATOR_HIGH_THRESHOLD_OUT,
					DIODE_SWITCH_SELECT_OUT}, 9'h000)
			end
		end
		for (int r = 0; r < 3; r++) begin
			ld(4'h2, r[2:0]);
			`CHK({FILTER_NEG_INPUT_SELECT_OUT, FILTER_POS_INPUT_SELECT_OUT}, 7'h58)
			`CHK({DISCHARGE_SWITCH_CODE_OUT, FEEDBACK_SWITCH_CODE_OUT}, {ds_t[r], ds_t[r]})
			`CHK({SWITCH_MODE_CODE_OUT, MAIN_AMP_REFERENCE_CODE_OUT, CONVERTER_LOW_REF_SELECT_OUT,
				CONVERTER_HIGH_REF_SELECT_OUT, GROUND_REFERENCE_CODE_OUT, EXTERNAL_REF_SELECT_OUT},
				{7'h14, 4'h7, 3'h0, 3'h0, 3'h1, 1'b1})
		end
		for (int r = 0; r < 6; r++) begin
			ld(4'h3, r[2:0]);
			`CHK({POSITIVE_SWITCH_CODE_OUT, MAIN_AMP_REFERENCE_CODE_OUT},
				{cc_ps_t[r], ((r == 0) ? 4'h8 : 4'h1)})
			`CHK({SWITCH_MODE_CODE_OUT, GROUND_REFERENCE_CODE_OUT, CONVERTER_LOW_REF_SELECT_OUT,
				EXTERNAL_REF_SELECT_OUT, DISCHARGE_SWITCH_CODE_OUT},
				{7'h06, 3'h4, 3'h7, 1'b0, 7'h00})
		end
		for (int f = 4; f < 6; f++) begin
			ld(f[3:0], 3'h0);
			`CHK({WINDOW_COMPARATOR_ENABLE_OUT, COMPARATOR_INPUT_CODE_OUT,
				COMPARATOR_LOW_THRESHOLD_OUT, COMPARATOR_HIGH_THRESHOLD_OUT}, 12'hbdd)
			`CHK({POSITIVE_SWITCH_CODE_OUT, DISCHARGE_SWITCH_CODE_OUT, MAIN_AMP_REFERENCE_CODE_OUT,
				EXTERNAL_REF_SELECT_OUT}, (f == 4) ? {7'h00, 7'h01, 4'h7, 1'b1}
				: {7'h01, 7'h00, 4'h8, 1'b0})
		end
		// Unknown function code must leave the last load in place
		ld(4'hf, 3'h0);
		`CHK({MAIN_AMP_REFERENCE_CODE_OUT, WINDOW_COMPARATOR_ENABLE_OUT}, 5'h11)
		rd(8'h00, 32'h0000_000f);
		// Load idle, last load refused, normal resistance mode, network still on
		rd(8'h10, 32'h0000_0008);
		report_and_stop();
	end
endmodule // meter_front_end_mode_decoder_tb_top
